// *** common/bitop_pkg.sv ***
// Package with opcodes, field positions, cycle counts and carriers for the bit instruction unit.
package bitop_pkg;
   localparam logic [7:0] OPC_BIT_OR      = 8'h07;
   localparam logic [7:0] OPC_BRANCH_CLR  = 8'h37;
   localparam int         FLD_REG_HI      = 7;
   localparam int         FLD_REG_LO      = 4;
   localparam int         FLD_BIT_HI      = 3;
   localparam int         FLD_BIT_LO      = 1;
   localparam int         FLD_SEL         = 0;
   localparam logic [3:0] CYC_BIT_OR      = 4'h6;
   localparam logic [3:0] CYC_BRANCH_CLR  = 4'ha;
   localparam logic [3:0] INS_BYTES       = 4'h3;
   localparam logic [15:0] PC_RESET       = 16'h0000;
   localparam logic [7:0] FLAGS_RESET     = 8'h00;
   localparam int         FLAG_C = 7;
   localparam int         FLAG_Z = 6;
   localparam int         FLAG_S = 5;
   localparam int         FLAG_V = 4;

   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] field;
      logic [7:0] third;
   } instr_t;

   typedef struct packed {
      logic       wr_en;
      logic [7:0] addr;
      logic [7:0] data;
   } reg_wr_t;
endpackage

// *** logic/bit_field_split.sv ***
// Splitter for the second instruction byte into register, bit number and selector.
module bit_field_split
   import bitop_pkg::*;
(
   // Second instruction byte.
   input  wire logic [7:0] field_in,
   // Decoded fields.
   output logic [3:0]      reg_addr_out,
   output logic [2:0]      bit_num_out,
   output logic            sel_out
);
   assign reg_addr_out = field_in[FLD_REG_HI:FLD_REG_LO];
   assign bit_num_out  = field_in[FLD_BIT_HI:FLD_BIT_LO];
   assign sel_out      = field_in[FLD_SEL];
endmodule // bit_field_split

// *** logic/bit_or_branch_unit.sv ***
// Execution unit for the bit-OR and branch-on-bit-clear instructions.
module bit_or_branch_unit
   import bitop_pkg::*;
(
   // Clock and reset.
   input  wire logic        sys_clk_in,
   input  wire logic        nrst_in,
   // Instruction issue.
   input  wire logic        start_in,
   input  wire instr_t      instr_in,
   // Operand values from the register file.
   input  wire logic [7:0]  reg_a_data_in,
   input  wire logic [7:0]  reg_b_data_in,
   // Register read addresses.
   output logic [7:0]       reg_a_addr_out,
   output logic [7:0]       reg_b_addr_out,
   // Register write and state.
   output reg_wr_t          reg_wr_out,
   output logic [15:0]      pc_out,
   output logic [7:0]       flags_out,
   output logic             busy_out,
   output logic             done_out,
   output logic             illegal_out
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_EXEC = 3'b010,
      ST_DONE = 3'b100
   } state_t;

   state_t      state_q, state_d;
   instr_t      ins_q, ins_d;
   logic [3:0]  cnt_q, cnt_d;
   logic [15:0] pc_q, pc_d;
   logic [7:0]  flags_q, flags_d;
   reg_wr_t     wr_q, wr_d;
   logic        done_q, done_d;
   logic        ill_q, ill_d;

   logic [3:0]  f_reg;
   logic [2:0]  f_bit;
   logic        f_sel;
   logic        res_bit;
   logic [7:0]  dst_new;
   logic [15:0] disp_ext;
   logic [7:0]  dst_old;
   logic [7:0]  dst_addr;
   logic [2:0]  dst_pos;
   logic        dst_bit;
   logic        src_bit;
   logic        tested_clear;
   logic [15:0] pc_seq;
   logic [15:0] pc_branch;
   logic        finish;
   logic        issue_ok;

   // Opcode decoding is needed both when an instruction is taken and when it completes.
   function automatic logic is_bit_or(input logic [7:0] op);
      return (op == OPC_BIT_OR);
   endfunction

   function automatic logic is_branch_clr(input logic [7:0] op);
      return (op == OPC_BRANCH_CLR);
   endfunction

   // Returns the byte with one bit replaced, so the other seven reach the write port untouched.
   function automatic logic [7:0] put_bit(input logic [7:0] value,
                                          input logic [2:0] pos,
                                          input logic       new_bit);
      logic [7:0] result;
      result      = value;
      result[pos] = new_bit;
      return result;
   endfunction

   bit_field_split u_split (
      .field_in     (ins_q.field),
      .reg_addr_out (f_reg),
      .bit_num_out  (f_bit),
      .sel_out      (f_sel)
   );

   // Port A is always the register of the second byte, port B the third byte's register.
   assign reg_a_addr_out = {4'h0, f_reg};
   assign reg_b_addr_out = ins_q.third;
   assign disp_ext = {{8{ins_q.third[7]}}, ins_q.third};

   // Both forms OR bit 0 of the second-byte register with bit b of the third-byte register;
   // the selector only decides which of the two registers takes the result.
   always_comb begin
      if (f_sel) begin
         // Third-byte register is the destination and its bit b is the target.
         dst_old  = reg_b_data_in;
         dst_addr = ins_q.third;
         dst_pos  = f_bit;
         dst_bit  = reg_b_data_in[f_bit];
         src_bit  = reg_a_data_in[0];
      end else begin
         // Second-byte register is the destination and its bit 0 is the target.
         dst_old  = reg_a_data_in;
         dst_addr = {4'h0, f_reg};
         dst_pos  = 3'h0;
         dst_bit  = reg_a_data_in[0];
         src_bit  = reg_b_data_in[f_bit];
      end
      res_bit = dst_bit | src_bit;
      dst_new = put_bit(dst_old, dst_pos, res_bit);
   end

   // A taken branch adds the signed displacement to the address of the next instruction.
   assign tested_clear = ~reg_a_data_in[f_bit];
   assign pc_seq       = pc_q + {12'h000, INS_BYTES};
   assign pc_branch    = pc_seq + disp_ext;
   assign finish       = (state_q == ST_EXEC) && (cnt_q == 4'h0);
   assign issue_ok     = start_in &&
                         (is_bit_or(instr_in.opcode) || is_branch_clr(instr_in.opcode));

   // Sequencer. Unknown opcodes are not latched, so a refused issue changes no state.
   always_comb begin
      state_d = state_q;
      ins_d   = ins_q;
      cnt_d   = cnt_q;
      unique case (state_q)
         ST_IDLE: begin
            if (issue_ok) begin
               ins_d   = instr_in;
               state_d = ST_EXEC;
               // The done cycle and the countdown's zero cycle are part of the budget.
               if (is_bit_or(instr_in.opcode)) begin
                  cnt_d = CYC_BIT_OR - 4'h2;
               end else begin
                  cnt_d = CYC_BRANCH_CLR - 4'h2;
               end
            end
         end
         ST_EXEC: begin
            // The countdown ends one cycle before done, so the results are registered by then.
            if (finish) begin
               state_d = ST_DONE;
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         ST_DONE: begin
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // Asynchronous reset loads only constants, so no reset path depends on other state.
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_q <= ST_IDLE;
         ins_q   <= '0;
         cnt_q   <= 4'h0;
      end else begin
         state_q <= state_d;
         ins_q   <= ins_d;
         cnt_q   <= cnt_d;
      end
   end

   // Results: program counter, flags and the one-cycle strobes.
   always_comb begin
      pc_d    = pc_q;
      flags_d = flags_q;
      wr_d    = '0;
      done_d  = (state_q == ST_DONE);
      // A refused issue only raises the illegal strobe.
      ill_d   = (state_q == ST_IDLE) && start_in && !issue_ok;
      if (finish) begin
         if (is_bit_or(ins_q.opcode)) begin
            pc_d            = pc_seq;
            // Only the destination is written; the source register is never a write target.
            wr_d.wr_en      = 1'b1;
            wr_d.addr       = dst_addr;
            wr_d.data       = dst_new;
            // Overflow is undefined after bit-OR and is simply left as it was.
            flags_d[FLAG_Z] = ~res_bit;
            flags_d[FLAG_S] = 1'b0;
         end else begin
            // Flags keep their value on both outcomes of the test.
            pc_d = tested_clear ? pc_branch : pc_seq;
         end
      end
   end

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pc_q    <= PC_RESET;
         flags_q <= FLAGS_RESET;
         wr_q    <= '0;
         done_q  <= 1'b0;
         ill_q   <= 1'b0;
      end else begin
         pc_q    <= pc_d;
         flags_q <= flags_d;
         wr_q    <= wr_d;
         done_q  <= done_d;
         ill_q   <= ill_d;
      end
   end

   // Busy is decoded from the state register, so it drops in the cycle in which done rises.
   assign reg_wr_out  = wr_q;
   assign pc_out      = pc_q;
   assign flags_out   = flags_q;
   assign busy_out    = (state_q != ST_IDLE);
   assign done_out    = done_q;
   assign illegal_out = ill_q;
endmodule // bit_or_branch_unit

// *** testbench/bit_unit_checker.sv ***
// Checker of timing, write and flag relations at the bit unit's ports.
module bit_unit_checker
   import bitop_pkg::*;
(
   // Clock, reset and issue.
   input wire logic        sys_clk_in,
   input wire logic        nrst_in,
   input wire logic        start_in,
   input wire instr_t      instr_in,
   // Results.
   input wire reg_wr_t     reg_wr_out,
   input wire logic [15:0] pc_out,
   input wire logic [7:0]  flags_out,
   input wire logic        busy_out,
   input wire logic        done_out,
   input wire logic        illegal_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge sys_clk_in);
   endclocking
   default disable iff (!nrst_in);
   logic go;
   logic [7:0] opc;
   assign go = start_in && !busy_out;
   assign opc = instr_in.opcode;
   sequence bor_run;
      busy_out [*6] ##1 (done_out && !busy_out);
   endsequence
   sequence bcl_run;
      busy_out [*8] ##1 busy_out ##1 busy_out ##1 (done_out && !busy_out);
   endsequence
   chk_bor_timing: assert property (go && opc == OPC_BIT_OR |=> bor_run)
      else $error("bit-OR length wrong");
   chk_bcl_timing: assert property (go && opc == OPC_BRANCH_CLR |=> bcl_run)
      else $error("branch length wrong");
   chk_bcl_flags: assert property (go && opc == OPC_BRANCH_CLR |-> ##3 $stable(flags_out) [*8])
      else $error("branch changed flags");
   chk_sign_clear: assert property (reg_wr_out.wr_en |-> !flags_out[FLAG_S])
      else $error("sign flag not cleared");
   chk_carry_kept: assert property (reg_wr_out.wr_en |-> $stable(flags_out[FLAG_C]))
      else $error("carry flag changed");
   chk_one_write: assert property (go && opc == OPC_BIT_OR |=> !reg_wr_out.wr_en [*5]
      ##1 reg_wr_out.wr_en ##1 !reg_wr_out.wr_en) else $error("write count wrong");
   chk_bad_opcode: assert property (go && opc != OPC_BIT_OR && opc != OPC_BRANCH_CLR
      |=> illegal_out && !busy_out) else $error("unknown opcode not flagged");
   chk_pc_moment: assert property ($changed(pc_out) |=> done_out)
      else $error("counter moved at wrong time");
endmodule // bit_unit_checker

bind bit_or_branch_unit bit_unit_checker chk (.sys_clk_in, .nrst_in, .start_in, .instr_in,
   .reg_wr_out, .pc_out, .flags_out, .busy_out, .done_out, .illegal_out);

// *** testbench/test_bit_or_branch_unit.sv ***
// Self-checking bench for the bit-OR and branch-on-clear unit.
module test_bit_or_branch_unit import bitop_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic        sys_clk_in;
   logic        nrst_in;
   logic        start_in;
   instr_t      instr_in;
   logic [7:0]  regs [256];
   logic [7:0]  a_addr, b_addr, flags, exp_fl;
   logic [15:0] pc, exp_pc;
   reg_wr_t     wr, last_wr;
   logic        busy, done, illegal;
   int          errors, samples_checked, writes;
`define CHK(g, w) begin samples_checked++; if ((g) !== (w)) begin errors++; \
 $display("mismatch at %0t: got %h want %h", $time, g, w); end end
   bit_or_branch_unit uut (.sys_clk_in, .nrst_in, .start_in, .instr_in,
      .reg_a_data_in(regs[a_addr]), .reg_b_data_in(regs[b_addr]), .reg_a_addr_out(a_addr),
      .reg_b_addr_out(b_addr), .reg_wr_out(wr), .pc_out(pc), .flags_out(flags),
      .busy_out(busy), .done_out(done), .illegal_out(illegal));
   always @(posedge sys_clk_in) if (wr.wr_en === 1'b1) begin
      last_wr <= wr;
      writes <= writes + 1;
   end
   task automatic stop_test();
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic issue(input logic [7:0] op, fld, thr, va, vb);
      int n;
      @(posedge sys_clk_in);
      start_in <= 1'b1;
      instr_in <= '{op, fld, thr};
      regs[{4'h0, fld[7:4]}] <= va;
      regs[thr] <= vb;
      @(posedge sys_clk_in);
      start_in <= 1'b0;
      @(negedge sys_clk_in);
      for (n = 0; n < 20 && done !== 1'b1 && illegal !== 1'b1; n++) @(negedge sys_clk_in);
      if (n == 20) begin
         errors++;
         stop_test();
      end
   endtask
   // Both forms OR bit 0 of the second-byte register with bit b of the third-byte one.
   task automatic bor(input logic [7:0] fld, thr, va, vb);
      int w;
      logic r;
      logic [7:0] d;
      w = writes;
      r = va[0] | vb[fld[3:1]];
      d = fld[0] ? vb : va;
      d[fld[0] ? fld[3:1] : 3'h0] = r;
      issue(OPC_BIT_OR, fld, thr, va, vb);
      exp_pc = exp_pc + INS_BYTES;
      exp_fl[FLAG_Z] = ~r;
      exp_fl[FLAG_S] = 1'b0;
      `CHK(last_wr, {1'b1, fld[0] ? thr : {4'h0, fld[7:4]}, d})
      `CHK(writes, w + 1)
      `CHK(flags, exp_fl)
      `CHK(pc, exp_pc)
   endtask
   task automatic bcl(input logic [7:0] fld, thr, va);
      issue(OPC_BRANCH_CLR, fld, thr, va, 8'h00);
      exp_pc = exp_pc + INS_BYTES + (va[fld[3:1]] ? 16'h0000 : {{8{thr[7]}}, thr});
      `CHK(pc, exp_pc)
      `CHK(flags, exp_fl)
   endtask
   task automatic or_low_form();
      bor(8'h12, 8'h21, 8'h03, 8'h07);
      bor(8'h12, 8'h21, 8'h02, 8'h50);
      bor(8'h12, 8'h21, 8'h02, 8'h01);
      bor(8'h12, 8'h21, 8'h00, 8'h02);
   endtask
   task automatic or_bit_form();
      for (int b = 0; b < 8; b++) bor({4'h2, b[2:0], 1'b1}, 8'h31, 8'h01, 8'h00);
      bor(8'h25, 8'h31, 8'h40, 8'hfa);
   endtask
   task automatic branch_reach();
      bcl(8'h17, 8'h7f, 8'h07);
      bcl(8'h13, 8'h80, 8'h07);
      bcl(8'h19, 8'h80, 8'h07);
   endtask
   task automatic bad_opcode();
      issue(8'hff, 8'h12, 8'h21, 8'h00, 8'h00);
      `CHK(illegal, 1'b1)
      `CHK(pc, exp_pc)
   endtask
   initial begin
      sys_clk_in = 1'b0;
      forever #20 sys_clk_in = ~sys_clk_in;
   end
   initial begin
      nrst_in = 1'b0;
      start_in = 1'b0;
      instr_in = '0;
      errors = 0;
      samples_checked = 0;
      writes = 0;
      exp_pc = PC_RESET;
      exp_fl = FLAGS_RESET;
      foreach (regs[i]) regs[i] = 8'h00;
      repeat (4) @(posedge sys_clk_in);
      nrst_in <= 1'b1;
      or_low_form();
      or_bit_form();
      branch_reach();
      bad_opcode();
      stop_test();
   end
endmodule // test_bit_or_branch_unit
